// ### rtl/lambda_sensor_sequencer.sv
// measurement sequencer, heater gate and sensor fault latching with wishbone regs
`timescale 1ns/1ps
`default_nettype none
module lambda_sensor_sequencer
#(
   parameter int FLT_CNT  = lambda_seq_pkg::FLT_CNT_DEF,
   parameter int BASE_DIV = 80
)
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // wishbone classic slave
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [7:0]          adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output logic      [31:0]         dat_o,
   output logic                     ack_o,
   // pins
   input  wire logic                sync_input_i,
   input  wire logic                heater_pwm_in_i,
   input  wire logic                heater_open_det_i,
   input  wire logic                heater_gnd_det_i,
   input  wire logic                heater_bat_det_i,
   input  wire logic                refcell_bat_det_i,
   input  wire logic                sense_bat_det_i,
   input  wire logic                pump_return_bat_det_i,
   input  wire logic                pump_pins_bat_det_i,
   input  wire logic [9:0]          adc_data_i,
   input  wire logic                adc_done_i,
   output logic                     heater_gate_out_o,
   output logic                     prot_gate_a_o,
   output logic                     prot_gate_b_o,
   output logic                     pump_source_en_o,
   output logic                     pump_pulldown_en_o,
   output logic                     impedance_test_switch_o,
   output logic                     charge_balance_sw_o,
   output logic                     bandgap_switch_o,
   output logic                     refcell_switch_o,
   output logic                     adc_start_o,
   output logic [1:0]               adc_mux_o,
   output logic [2:0]               adc_gain_o,
   output logic                     meas_clk_o
);
   import lambda_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register file state
   logic [31:0] ctrl_reg,   ctrl_next;
   logic [31:0] timing_reg, timing_next;
   logic [31:0] dat_reg,    dat_next;
   logic        ack_reg,    ack_next;
   logic [2:0]  flags_reg,  flags_next;      // sense bat a/b/c
   logic [2:0]  hflags_reg, hflags_next;     // heater open/gnd/bat
   logic        latched_reg, latched_next;
   logic        pulldown_off_reg, pulldown_off_next;
   logic [2:0]  count_reg,  count_next;
   logic [9:0]  res_reg [4];
   logic [9:0]  res_next [4];

   // sequencer state
   seq_state_t  st_reg, st_next;
   logic [6:0]  imp_t_reg, imp_t_next;
   logic [6:0]  bg_t_reg,  bg_t_next;
   logic [2:0]  rc_t_reg,  rc_t_next;
   logic [7:0]  tcnt_reg,  tcnt_next;
   logic        sync_q_reg;
   logic        conv_wait_reg, conv_wait_next;
   logic        hg_reg, hg_next;
   logic        start_reg, start_next;
   logic [1:0]  mux_reg, mux_next;
   logic [2:0]  gain_reg, gain_next;

   logic        tick;
   logic [2:0]  det_v;
   logic        sr_det;
   logic        any_det;
   logic        wr_en, rd_en;
   logic        busy;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (be[i]) r[8*i +: 8] = new_v[8*i +: 8];
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // submodules
   sm_tick_gen #(.BASE_DIV(BASE_DIV)) u_tick (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .period_sel_i(timing_reg[TM_MCP_LSB +: 2]),
      .tick_o      (tick)
   );

   // pump return check only counts while a protection gate is on
   assign sr_det  = pump_return_bat_det_i && (prot_gate_a_o || prot_gate_b_o);
   assign any_det = refcell_bat_det_i || sense_bat_det_i || sr_det || pump_pins_bat_det_i;

   fault_filter #(.FLT_CNT(FLT_CNT)) u_flt_a (
      .clk_i (clk_i), .rst_i(rst_i), .tick_i(tick),
      .cond_i(refcell_bat_det_i), .valid_o(det_v[0]));
   fault_filter #(.FLT_CNT(FLT_CNT)) u_flt_b (
      .clk_i (clk_i), .rst_i(rst_i), .tick_i(tick),
      .cond_i(sense_bat_det_i), .valid_o(det_v[1]));
   fault_filter #(.FLT_CNT(FLT_CNT)) u_flt_c (
      .clk_i (clk_i), .rst_i(rst_i), .tick_i(tick),
      .cond_i(sr_det || pump_pins_bat_det_i), .valid_o(det_v[2]));

   ////////////////////////////////////////////////////////////////////////////
   // bus and fault latching
   assign wr_en = cyc_i && stb_i && we_i && !ack_reg;
   assign rd_en = cyc_i && stb_i && !we_i && !ack_reg;
   assign busy  = (st_reg != SQ_IDLE);

   always_comb
   begin
      ctrl_next         = ctrl_reg;
      timing_next       = timing_reg;
      dat_next          = dat_reg;
      ack_next          = cyc_i && stb_i && !ack_reg;
      flags_next        = flags_reg | det_v;
      hflags_next       = hflags_reg | {heater_bat_det_i, heater_gnd_det_i,
                                        heater_open_det_i};
      latched_next      = latched_reg | (|det_v);
      pulldown_off_next = pulldown_off_reg | any_det;
      if (wr_en && adr_i == OFS_CTRL)
         ctrl_next = merge(ctrl_reg, dat_i, sel_i);
      if (wr_en && adr_i == OFS_TIMING)
         timing_next = merge(timing_reg, dat_i, sel_i) & 32'h0007_ffff;
      // clear takes one cycle; a fault still present sets again, set wins
      if (ctrl_reg[CTL_CLEAR])
      begin
         flags_next        = det_v;
         hflags_next       = {heater_bat_det_i, heater_gnd_det_i, heater_open_det_i};
         latched_next      = |det_v;
         pulldown_off_next = any_det;
         ctrl_next[CTL_CLEAR] = 1'b0;
      end
      if (rd_en)
      begin
         case (adr_i)
            OFS_CTRL:    dat_next = ctrl_reg;
            OFS_TIMING:  dat_next = timing_reg;
            OFS_STATUS:  dat_next = {20'h00000, ctrl_reg[CTL_CLEAR], busy, flags_reg,
                                     hflags_reg[2], hflags_reg[1], hflags_reg[0],
                                     1'b0, count_reg};
            // fv beside impedance pre; impedance post beside refcell
            OFS_ADC_REQ: dat_next = {6'h00, res_reg[1], 6'h00, res_reg[2]};
            8'h10:       dat_next = {6'h00, res_reg[3], 6'h00, res_reg[0]};
            default:     dat_next = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timing sequencer
   always_comb
   begin
      st_next        = st_reg;
      imp_t_next     = imp_t_reg;
      bg_t_next      = bg_t_reg;
      rc_t_next      = rc_t_reg;
      tcnt_next      = tcnt_reg;
      conv_wait_next = conv_wait_reg;
      start_next     = 1'b0;
      mux_next       = mux_reg;
      gain_next      = gain_reg;
      count_next     = count_reg;
      for (int i = 0; i < 4; i++) res_next[i] = res_reg[i];
      // heater: follow inverted pwm when idle, hold when busy
      hg_next = busy ? hg_reg : !heater_pwm_in_i;
      case (st_reg)
         SQ_IDLE:
            // edges in other states never reach here, so are dropped
            if (ctrl_reg[CTL_SYNC] ? (sync_input_i && !sync_q_reg) : tick)
            begin
               imp_t_next = timing_reg[TM_IMP_LSB +: 7];
               bg_t_next  = timing_reg[TM_BG_LSB  +: 7];
               rc_t_next  = timing_reg[TM_RC_LSB  +: 3];
               st_next    = SQ_REFCELL;
               tcnt_next  = 8'h00;
               conv_wait_next = 1'b0;
            end
         SQ_REFCELL, SQ_FV, SQ_IMP_PRE, SQ_IMP_POST:
            if (!conv_wait_reg)
            begin
               // mux order refcell, fv, impedance pre and post
               mux_next   = (st_reg == SQ_REFCELL) ? MUX_REFCELL :
                            (st_reg == SQ_FV) ? MUX_FV : MUX_IMPAMP;
               gain_next  = (st_reg == SQ_FV) ? ctrl_reg[CTL_GAIN_LSB +: 3]
                                              : GAIN_UNITY;
               start_next = 1'b1;
               conv_wait_next = 1'b1;
            end
            else if (adc_done_i)
            begin
               conv_wait_next = 1'b0;
               // 10-bit results; fv code is offset binary about 512
               // post-pulse state code skips the pulse state, so it is mapped apart
               res_next[(st_reg == SQ_IMP_POST) ? 2'd3 : 2'(3'(st_reg) - 3'd1)] = adc_data_i;
               tcnt_next = 8'h00;
               case (st_reg)
                  SQ_REFCELL: st_next = SQ_FV;
                  SQ_FV:      st_next = SQ_IMP_PRE;
                  SQ_IMP_PRE: st_next = SQ_PULSE;
                  default:    st_next = SQ_TAIL;
               endcase
            end
         SQ_PULSE:
            if (tick)
            begin
               tcnt_next = tcnt_reg + 8'h01;
               if (tcnt_reg >= {1'b0, imp_t_reg})
                  st_next = SQ_IMP_POST;
            end
         SQ_TAIL:
            if (tick)
            begin
               tcnt_next = tcnt_reg + 8'h01;
               if (tcnt_reg >= {1'b0, bg_t_reg} + {5'h00, rc_t_reg})
               begin
                  st_next    = SQ_IDLE;
                  count_next = count_reg + 3'h1;
               end
            end
         default: st_next = SQ_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_reg         <= CTRL_RESET;
         timing_reg       <= TIMING_RESET;
         dat_reg          <= 32'h0000_0000;
         ack_reg          <= 1'b0;
         flags_reg        <= 3'h0;
         hflags_reg       <= 3'h0;
         latched_reg      <= 1'b0;
         pulldown_off_reg <= 1'b0;
         count_reg        <= 3'h0;
         st_reg           <= SQ_IDLE;
         imp_t_reg        <= 7'h00;
         bg_t_reg         <= 7'h00;
         rc_t_reg         <= 3'h0;
         tcnt_reg         <= 8'h00;
         sync_q_reg       <= 1'b0;
         conv_wait_reg    <= 1'b0;
         hg_reg           <= 1'b0;
         start_reg        <= 1'b0;
         mux_reg          <= 2'h0;
         gain_reg         <= 3'h0;
         for (int i = 0; i < 4; i++) res_reg[i] <= 10'h000;
      end
      else
      begin
         ctrl_reg         <= ctrl_next;
         timing_reg       <= timing_next;
         dat_reg          <= dat_next;
         ack_reg          <= ack_next;
         flags_reg        <= flags_next;
         hflags_reg       <= hflags_next;
         latched_reg      <= latched_next;
         pulldown_off_reg <= pulldown_off_next;
         count_reg        <= count_next;
         st_reg           <= st_next;
         imp_t_reg        <= imp_t_next;
         bg_t_reg         <= bg_t_next;
         rc_t_reg         <= rc_t_next;
         tcnt_reg         <= tcnt_next;
         sync_q_reg       <= sync_input_i;
         conv_wait_reg    <= conv_wait_next;
         hg_reg           <= hg_next;
         start_reg        <= start_next;
         mux_reg          <= mux_next;
         gain_reg         <= gain_next;
         for (int i = 0; i < 4; i++) res_reg[i] <= res_next[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output registers
   logic pga_reg, pgb_reg, pump_reg, pd_reg, imp_reg, cb_reg, bgs_reg, rcs_reg, mclk_reg;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pga_reg  <= 1'b0;
         pgb_reg  <= 1'b0;
         pump_reg <= 1'b0;
         pd_reg   <= 1'b1;
         imp_reg  <= 1'b0;
         cb_reg   <= 1'b0;
         bgs_reg  <= 1'b0;
         rcs_reg  <= 1'b0;
         mclk_reg <= 1'b0;
      end
      else
      begin
         // enables resume straight after a clear, unaligned to pump clock
         pga_reg  <= ctrl_next[CTL_PG_A] && !latched_next;
         pgb_reg  <= ctrl_next[CTL_PG_B] && !latched_next;
         pump_reg <= ctrl_next[CTL_PUMP_EN] && !latched_next;
         pd_reg   <= !pulldown_off_next;
         imp_reg  <= ctrl_next[CTL_IMP_EN] && !latched_next && st_next == SQ_PULSE;
         cb_reg   <= ctrl_next[CTL_CB_EN] && !latched_next && st_next == SQ_TAIL;
         bgs_reg  <= (st_next == SQ_TAIL) && (tcnt_next < {1'b0, bg_t_next});
         rcs_reg  <= (st_next == SQ_TAIL) && (tcnt_next >= {1'b0, bg_t_next});
         // measurement clock high while busy; its fall counts the cycle
         mclk_reg <= (st_next != SQ_IDLE);
      end
   end

   assign dat_o                   = dat_reg;
   assign ack_o                   = ack_reg;
   assign heater_gate_out_o       = hg_reg;
   assign prot_gate_a_o           = pga_reg;
   assign prot_gate_b_o           = pgb_reg;
   assign pump_source_en_o        = pump_reg;
   assign pump_pulldown_en_o      = pd_reg;
   assign impedance_test_switch_o = imp_reg;
   assign charge_balance_sw_o     = cb_reg;
   assign bandgap_switch_o        = bgs_reg;
   assign refcell_switch_o        = rcs_reg;
   assign adc_start_o             = start_reg;
   assign adc_mux_o               = mux_reg;
   assign adc_gain_o              = gain_reg;
   assign meas_clk_o              = mclk_reg;
endmodule // lambda_sensor_sequencer
`default_nettype wire

// ### pkg/lambda_seq_pkg.sv
// constants, register fields and states for the lambda sensor sequencer
package lambda_seq_pkg;
   localparam int          CLK_HZ         = 20_000_000;
   localparam int          ADC_BITS       = 10;
   localparam logic [9:0]  FV_ZERO_CODE   = 10'h200;
   localparam logic [2:0]  GAIN_UNITY     = 3'h0;
   localparam int          FLT_CNT_DEF    = 8;
   // register offsets (byte addresses)
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_TIMING     = 8'h04;
   localparam logic [7:0]  OFS_STATUS     = 8'h08;
   localparam logic [7:0]  OFS_ADC_REQ    = 8'h0c;
   // ctrl fields
   localparam int          CTL_SYNC       = 0;
   localparam int          CTL_PG_A       = 1;
   localparam int          CTL_PG_B       = 2;
   localparam int          CTL_PUMP_EN    = 3;
   localparam int          CTL_IMP_EN     = 4;
   localparam int          CTL_CB_EN      = 5;
   localparam int          CTL_CLEAR      = 6;
   localparam int          CTL_GAIN_LSB   = 8;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   // timing fields
   localparam int          TM_MCP_LSB     = 0;
   localparam int          TM_IMP_LSB     = 2;
   localparam int          TM_BG_LSB      = 9;
   localparam int          TM_RC_LSB      = 16;
   localparam logic [31:0] TIMING_RESET   = 32'h0001_0a0a;
   // status fields
   localparam int          ST_COUNT_LSB   = 0;
   localparam int          ST_HOPEN       = 4;
   localparam int          ST_HGND        = 5;
   localparam int          ST_HBAT        = 6;
   localparam int          ST_SBAT_A      = 7;
   localparam int          ST_SBAT_B      = 8;
   localparam int          ST_SBAT_C      = 9;
   localparam int          ST_BUSY        = 10;
   localparam int          ST_CLEAR       = 11;
   // sequencer states
   typedef enum logic [2:0] {
      SQ_IDLE, SQ_REFCELL, SQ_FV, SQ_IMP_PRE, SQ_PULSE, SQ_IMP_POST, SQ_TAIL
   } seq_state_t;
   // adc mux selections
   typedef enum logic [1:0] {
      MUX_REFCELL, MUX_FV, MUX_IMPAMP
   } mux_sel_t;
endpackage

// ### rtl/sm_tick_gen.sv
// state machine clock divider giving one tick per selectable period
`timescale 1ns/1ps
`default_nettype none
module sm_tick_gen
   import lambda_seq_pkg::*;
#(
   parameter int BASE_DIV = 80
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] period_sel_i,
   output logic            tick_o
);
   initial if (BASE_DIV < 2) $error("BASE_DIV too small");
   logic [11:0] cnt_reg;
   logic [11:0] cnt_next;
   logic        tick_reg;
   logic        tick_next;
   logic [11:0] limit;
   always_comb
   begin
      // period doubles with each select step
      limit     = 12'(BASE_DIV << period_sel_i) - 12'h001;
      tick_next = (cnt_reg >= limit);
      cnt_next  = tick_next ? 12'h000 : cnt_reg + 12'h001;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_reg  <= 12'h000;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end
   assign tick_o = tick_reg;
endmodule // sm_tick_gen
`default_nettype wire

// ### rtl/fault_filter.sv
// short-to-battery filter: count while condition persists, flag when reached
`timescale 1ns/1ps
`default_nettype none
module fault_filter
   import lambda_seq_pkg::*;
#(
   parameter int FLT_CNT = FLT_CNT_DEF
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic tick_i,
   input  wire logic cond_i,
   output logic      valid_o
);
   initial if (FLT_CNT < 1 || FLT_CNT > 255) $error("FLT_CNT out of range");
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   always_comb
   begin
      if (!cond_i)
         cnt_next = 8'h00;
      else if (tick_i && cnt_reg != 8'(FLT_CNT))
         cnt_next = cnt_reg + 8'h01;
      else
         cnt_next = cnt_reg;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt_reg <= 8'h00;
      else
         cnt_reg <= cnt_next;
   end
   assign valid_o = cond_i && (cnt_reg == 8'(FLT_CNT));
endmodule // fault_filter
`default_nettype wire

// ### verif/adc_model.sv
// behavioural converter answering each start with a result
`timescale 1ns/1ps
`default_nettype none
module adc_model
   import lambda_seq_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic [1:0] mux_i,
   output logic            done_o,
   output logic [9:0]      data_o
);
   logic [2:0] wait_reg = 3'h0;
   logic [1:0] mux_reg  = 2'h0;
   initial
   begin
      data_o = 10'h000;
      done_o = 1'b0;
   end
   always @(posedge clk_i)
   begin
      done_o <= 1'b0;
      // result bus churns outside done so stale values are never trusted
      data_o <= ~data_o;
      if (start_i)
      begin
         wait_reg <= 3'h3;
         mux_reg  <= mux_i;
      end
      else if (wait_reg != 3'h0)
         wait_reg <= wait_reg - 3'h1;
      if (wait_reg == 3'h1)
      begin
         done_o <= 1'b1;
         data_o <= (mux_reg == MUX_FV) ? FV_ZERO_CODE : {8'h5a, mux_reg};
      end
   end
endmodule // adc_model
`default_nettype wire

// ### verif/lambda_seq_properties.sv
// port-level checker for the lambda sensor sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_checker
   import lambda_seq_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       ack_o,
   input wire logic       heater_pwm_in_i,
   input wire logic       refcell_bat_det_i,
   input wire logic       sense_bat_det_i,
   input wire logic       pump_pins_bat_det_i,
   input wire logic       pump_return_bat_det_i,
   input wire logic       heater_gate_out_o,
   input wire logic       prot_gate_a_o,
   input wire logic       prot_gate_b_o,
   input wire logic       pump_source_en_o,
   input wire logic       pump_pulldown_en_o,
   input wire logic       adc_start_o,
   input wire logic [1:0] adc_mux_o,
   input wire logic [2:0] adc_gain_o,
   input wire logic       meas_clk_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire       others = refcell_bat_det_i | sense_bat_det_i | pump_pins_bat_det_i;
   logic [5:0] held_reg;
   // saturating count of a persisting sensor short
   always_ff @(posedge clk_i)
      held_reg <= (rst_i || !others) ? 6'h0 : held_reg + {5'h0, held_reg != 6'h3f};
   ////////////////////////////////////////////////////////////////////////////
   ack_one_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   unity_gain_a: assert property (adc_start_o && adc_mux_o != MUX_FV
      |-> adc_gain_o == GAIN_UNITY) else $error("gain not unity");
   gate_idle_a: assert property (!meas_clk_o [*3] ##0 $stable(heater_pwm_in_i)
      |-> heater_gate_out_o == !heater_pwm_in_i) else $error("gate not inverse");
   gate_frozen_a: assert property (meas_clk_o && $past(meas_clk_o)
      |-> $stable(heater_gate_out_o)) else $error("gate moved");
   pulldown_drop_a: assert property (others |=> !pump_pulldown_en_o)
      else $error("pulldown kept");
   return_mask_a: assert property (pump_return_bat_det_i && !others && pump_pulldown_en_o
      && !prot_gate_a_o && !prot_gate_b_o |=> pump_pulldown_en_o) else $error("mask lost");
   gates_latch_a: assert property (held_reg == 6'h28
      |-> !prot_gate_a_o && !prot_gate_b_o && !pump_source_en_o) else $error("no latch");
   conv_order_a: assert property ($rose(meas_clk_o)
      |-> ##[0:20] adc_start_o && adc_mux_o == MUX_REFCELL) else $error("no refcell conv");
   cycle_c: cover property ($rose(meas_clk_o));
   latch_c: cover property (held_reg == 6'h28);
   bus_c: cover property (ack_o);
endmodule // seq_checker
bind lambda_sensor_sequencer seq_checker i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
   .heater_pwm_in_i, .refcell_bat_det_i, .sense_bat_det_i, .pump_pins_bat_det_i,
   .pump_return_bat_det_i, .heater_gate_out_o, .prot_gate_a_o, .prot_gate_b_o,
   .pump_source_en_o, .pump_pulldown_en_o, .adc_start_o, .adc_mux_o, .adc_gain_o,
   .meas_clk_o);
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the lambda sensor sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import lambda_seq_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic        sync_input_i = 1'b0, heater_pwm_in_i = 1'b0, adc_done_i;
   logic        heater_open_det_i = 1'b0, heater_gnd_det_i = 1'b0, heater_bat_det_i = 1'b0;
   logic        refcell_bat_det_i = 1'b0, sense_bat_det_i = 1'b0, pump_return_bat_det_i = 1'b0;
   logic        pump_pins_bat_det_i = 1'b0, ack_o, heater_gate_out_o, prot_gate_a_o;
   logic        prot_gate_b_o, pump_source_en_o, pump_pulldown_en_o, impedance_test_switch_o;
   logic        charge_balance_sw_o, bandgap_switch_o, refcell_switch_o, adc_start_o, meas_clk_o;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o, rd, hg;
   logic [9:0]  adc_data_i;
   logic [1:0]  adc_mux_o;
   logic [2:0]  adc_gain_o, base;
   int          errors = 0, total_checks = 0;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
   row_t rows [7] = '{'{0, OFS_TIMING, 0, TIMING_RESET}, '{0, OFS_CTRL, 0, CTRL_RESET},
      '{1, 8'h14, 32'hffff_ffff, 0}, '{0, 8'h14, 0, 0}, '{1, OFS_TIMING, 32'hffff_ffff, 0},
      '{0, OFS_TIMING, 0, 32'h0007_ffff}, '{1, OFS_TIMING, 32'h0001_0a14, 0}};
   always #25 clk_i = ~clk_i;
   // short divider and filter keep cycles to a few dozen clocks
   lambda_sensor_sequencer #(.FLT_CNT(2), .BASE_DIV(2)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sync_input_i, .heater_pwm_in_i,
      .heater_open_det_i, .heater_gnd_det_i, .heater_bat_det_i, .refcell_bat_det_i,
      .sense_bat_det_i, .pump_return_bat_det_i, .pump_pins_bat_det_i, .adc_data_i, .adc_done_i,
      .heater_gate_out_o, .prot_gate_a_o, .prot_gate_b_o, .pump_source_en_o, .pump_pulldown_en_o,
      .impedance_test_switch_o, .charge_balance_sw_o, .bandgap_switch_o, .refcell_switch_o,
      .adc_start_o, .adc_mux_o, .adc_gain_o, .meas_clk_o);
   adc_model i_adc (.clk_i, .start_i(adc_start_o), .mux_i(adc_mux_o), .done_o(adc_done_i),
      .data_o(adc_data_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50)
      begin
         chk(0, 1);
         end_sim();
      end
   endtask
   task automatic wait_mclk(input logic v);
      int n;
      for (n = 0; n < 600 && meas_clk_o !== v; n++)
         @(posedge clk_i);
      if (n >= 600)
      begin
         chk(meas_clk_o, v);
         end_sim();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({pump_pulldown_en_o, prot_gate_a_o, prot_gate_b_o, meas_clk_o}, 4'h8);
      heater_pwm_in_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(heater_gate_out_o, 1'b0);
      foreach (rows[i])
      begin
         wb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w)
            chk(rd, rows[i].e);
      end
      // non-unity gain so the forced gain on other inputs is visible
      wb(1'b1, OFS_CTRL, 32'h30f);
      // free-running cycles since reset leave an unknown count behind
      wait_mclk(1'b0);
      wb(1'b0, OFS_STATUS, 0);
      base = rd[2:0];
      // each cycle gets an extra sync edge mid-run that must be ignored
      for (int k = 1; k <= 8; k++)
      begin
         sync_input_i <= 1'b1;
         wait_mclk(1'b1);
         hg = heater_gate_out_o;
         heater_pwm_in_i <= ~heater_pwm_in_i;
         sync_input_i <= 1'b0;
         repeat (4) @(posedge clk_i);
         sync_input_i <= 1'b1;
         repeat (4) @(posedge clk_i);
         chk(heater_gate_out_o, hg);
         sync_input_i <= 1'b0;
         wait_mclk(1'b0);
         repeat (60) @(posedge clk_i);
         chk({meas_clk_o, heater_gate_out_o}, {1'b0, ~heater_pwm_in_i});
         wb(1'b0, OFS_STATUS, 0);
         chk(rd[2:0], 3'(base + 3'(k)));
      end
      wb(1'b0, OFS_ADC_REQ, 0);
      chk(rd, {6'h00, FV_ZERO_CODE, 6'h00, 8'h5a, 2'(MUX_IMPAMP)});
      wb(1'b0, 8'h10, 0);
      chk(rd, {6'h00, 8'h5a, 2'(MUX_IMPAMP), 6'h00, 8'h5a, 2'(MUX_REFCELL)});
      wb(1'b1, OFS_CTRL, 32'h0e);
      wait_mclk(1'b1);
      wait_mclk(1'b0);
      wait_mclk(1'b1);
      chk(meas_clk_o, 1'b1);
      // back to sync mode so the busy bit stays clear in the status reads
      wb(1'b1, OFS_CTRL, 32'h0f);
      for (int i = 0; i < 3; i++)
      begin
         {pump_pins_bat_det_i, sense_bat_det_i, refcell_bat_det_i} <= 3'(1 << i);
         {heater_bat_det_i, heater_gnd_det_i, heater_open_det_i} <= 3'(1 << i);
         repeat (2) @(posedge clk_i);
         chk(pump_pulldown_en_o, 1'b0);
         repeat (100) @(posedge clk_i);
         chk({prot_gate_a_o, prot_gate_b_o, pump_source_en_o}, 3'h0);
         {pump_pins_bat_det_i, sense_bat_det_i, refcell_bat_det_i} <= 3'h0;
         {heater_bat_det_i, heater_gnd_det_i, heater_open_det_i} <= 3'h0;
         repeat (20) @(posedge clk_i);
         wb(1'b0, OFS_STATUS, 0);
         chk({rd[9:4], pump_pulldown_en_o}, {3'(1 << i), 3'(1 << i), 1'b0});
         wb(1'b1, OFS_CTRL, 32'h4f);
         repeat (4) @(posedge clk_i);
         wb(1'b0, OFS_STATUS, 0);
         chk(rd[11:4], 8'h00);
         wb(1'b0, OFS_CTRL, 0);
         chk(rd[6], 1'b0);
         chk({prot_gate_a_o, prot_gate_b_o, pump_source_en_o, pump_pulldown_en_o}, 4'hf);
      end
      wb(1'b1, OFS_CTRL, 32'h08);
      repeat (3) @(posedge clk_i);
      pump_return_bat_det_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      chk(pump_pulldown_en_o, 1'b1);
      pump_return_bat_det_i <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, OFS_STATUS, 0);
      chk({rd[2:0], pump_pulldown_en_o}, 4'h1);
      end_sim();
   end
endmodule // testbench
`default_nettype wire
